// ==== hdl/tcc_top.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_top
  import tcc_pkg::*;
#(
  parameter int FILT_LEN = `TCC_FILT_LEN
) (
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     sys_rst,
  // register port
  input  wire tcc_bus_t reg_req,
  output var  logic [7:0] rd_data,
  // timer pins
  input  wire logic     chan_a_pin,
  input  wire logic     chan_b_pin,
  input  wire logic     chan_c_pin,
  input  wire logic     chan_d_pin,
  input  wire logic     external_trigger_pin,
  input  wire logic     external_count_clock_pin,
  input  wire logic     cutoff_input_pin_n,
  // on-chip clock sources, sampled
  input  wire logic     slow_osc_signal,
  input  wire logic     fast_osc_clock,
  // requests and output control
  output var  logic       timer_irq,
  output var  logic [4:0] irq_req,
  output var  logic [3:0] chan_output_disable
);

  tcc_state_t r;
  tcc_state_t nx;

  logic       pwm2_sel;
  logic [3:0] chan_timer;
  logic [3:0] chan_cap;
  logic [3:0] cap_ev;
  logic [3:0] match;
  logic [3:0] src_now;
  logic [3:0] src_old;
  logic [3:0][1:0] edge_sel;
  logic [4:0] raw_in;
  logic [4:0] filt_en;
  logic       samp_tick;
  logic       tick;
  logic       wrap_ev;
  logic       trig_ev;
  logic [7:0] ev;
  logic       bfc;
  logic       bfd;
  logic       pend;

  // mode decode: pwm2 is selected by a 0 in bit 3, pwm per channel b to d
  assign pwm2_sel = ~r.mode[3];
  assign bfc      = r.mode[4];
  assign bfd      = r.mode[5];
  assign chan_timer[0] = ~pwm2_sel;
  assign chan_timer[1] = ~pwm2_sel & ~r.mode[0];
  assign chan_timer[2] = ~pwm2_sel & ~r.mode[1];
  assign chan_timer[3] = ~pwm2_sel & ~r.mode[2];

  // io control only counts in timer mode, otherwise channels compare
  assign chan_cap[0] = chan_timer[0] & r.ioab[2];
  assign chan_cap[1] = chan_timer[1] & r.ioab[6];
  assign chan_cap[2] = chan_timer[2] & r.iocd[2];
  assign chan_cap[3] = chan_timer[3] & r.iocd[6];
  assign edge_sel[0] = r.ioab[1:0];
  assign edge_sel[1] = r.ioab[5:4];
  assign edge_sel[2] = r.iocd[1:0];
  assign edge_sel[3] = r.iocd[5:4];

  // channel a may capture on the slow oscillator instead of its pin
  assign src_now[0] = r.ioab[3] ? r.flvl[0] : slow_osc_signal;
  assign src_old[0] = r.ioab[3] ? r.fprev[0] : r.slow_prev;
  assign src_now[3:1] = r.flvl[3:1];
  assign src_old[3:1] = r.fprev[3:1];

  // count tick; ext and fast sources are sampled on clk_sys, which is why
  // an external pulse must be high at one clk_sys edge and low at the edge before to be seen
  always_comb begin
    case (r.cctl[6:4])
      `TCC_SRC_DIV1:  tick = 1'b1;
      `TCC_SRC_DIV2:  tick = r.presc[0];
      `TCC_SRC_DIV4:  tick = &r.presc[1:0];
      `TCC_SRC_DIV8:  tick = &r.presc[2:0];
      `TCC_SRC_DIV32: tick = &r.presc[4:0];
      `TCC_SRC_EXT:   tick = external_count_clock_pin & ~r.ext_prev;
      `TCC_SRC_FAST:  tick = fast_osc_clock & ~r.fast_prev;
      default:        tick = 1'b0;
    endcase
    tick = tick & r.mode[7];
  end

  // filter sampling clock: f1, f8, f32 or the count tick
  always_comb begin
    case (r.filt[7:6])
      2'h0:    samp_tick = 1'b1;
      2'h1:    samp_tick = &r.presc[2:0];
      2'h2:    samp_tick = &r.presc[4:0];
      default: samp_tick = tick;
    endcase
  end

  assign raw_in  = {external_trigger_pin, chan_d_pin, chan_c_pin, chan_b_pin, chan_a_pin};
  assign filt_en = {r.filt[4], r.filt[3:0]};

  // per channel capture edge and compare match
  for (genvar i = 0; i < 4; i++) begin : g_chan
    logic rise;
    logic fall;
    assign rise = src_now[i] & ~src_old[i];
    assign fall = ~src_now[i] & src_old[i];
    assign cap_ev[i] = chan_cap[i] & (
                       ((edge_sel[i] == `TCC_EDGE_RISE) & rise) |
                       ((edge_sel[i] == `TCC_EDGE_FALL) & fall) |
                       ((edge_sel[i] == `TCC_EDGE_BOTH) & (rise | fall)));
    assign match[i] = ~chan_cap[i] & tick & (r.cnt == r.gen[i]);
  end

  assign wrap_ev = tick & (r.cnt == `TCC_CNT_MAX);
  assign trig_ev = r.flvl[4] & ~r.fprev[4];
  assign ev      = {wrap_ev, 3'h0, cap_ev | match};
  assign pend    = |(r.flags & r.ien & `TCC_FLAG_VALID);

  // next state: bus access first, hardware events override
  always_comb begin
    nx           = r;
    nx.rdata     = 8'h00;
    nx.presc     = r.presc + 5'h01;
    nx.ext_prev  = external_count_clock_pin;
    nx.fast_prev = fast_osc_clock;
    nx.slow_prev = slow_osc_signal;
    nx.fprev     = r.flvl;

    // three equal samples in a row settle a new level
    for (int k = 0; k < 5; k++) begin
      if (!filt_en[k]) begin
        nx.flvl[k] = raw_in[k];
      end else if (samp_tick) begin
        nx.fsamp[k] = {r.fsamp[k][1:0], raw_in[k]};
        if (nx.fsamp[k] == {FILT_LEN{raw_in[k]}}) begin
          nx.flvl[k] = raw_in[k];
        end
      end
    end

    // register writes
    if (reg_req.wr) begin
      if (reg_req.addr == `TCC_ADR_MODE) begin
        nx.mode = reg_req.wdata | `TCC_MODE_ONES;
      end else if (reg_req.addr == `TCC_ADR_CCTL) begin
        nx.cctl = reg_req.wdata;
      end else if (reg_req.addr == `TCC_ADR_IEN) begin
        nx.ien = (reg_req.wdata & `TCC_FLAG_VALID) | `TCC_RSV_ONES;
      end else if (reg_req.addr == `TCC_ADR_FLAGS) begin
        // only flags seen at 1 by a read can be cleared, ones do nothing
        nx.flags   = r.flags & ~(r.rd_seen & ~reg_req.wdata & `TCC_FLAG_VALID);
        nx.rd_seen = 8'h00;
      end else if (reg_req.addr == `TCC_ADR_IOAB) begin
        nx.ioab = reg_req.wdata | `TCC_IOAB_ONES;
      end else if (reg_req.addr == `TCC_ADR_IOCD) begin
        nx.iocd = reg_req.wdata | `TCC_IOCD_ONES;
      end else if (reg_req.addr == `TCC_ADR_CNT_LO) begin
        nx.cnt[7:0] = reg_req.wdata;
      end else if (reg_req.addr == `TCC_ADR_CNT_HI) begin
        nx.cnt[15:8] = reg_req.wdata;
      end else if (reg_req.addr == `TCC_ADR_FILT) begin
        nx.filt = reg_req.wdata & `TCC_FILT_WMASK;
      end else if (reg_req.addr == `TCC_ADR_OMASK) begin
        nx.omask = reg_req.wdata | `TCC_RSV_ONES;
      end else begin
        for (int g = 0; g < 4; g++) begin
          if (reg_req.addr == `TCC_ADR_GEN + 10'(2 * g)) begin
            nx.gen[g][7:0] = reg_req.wdata;
          end else if (reg_req.addr == `TCC_ADR_GEN + 10'(2 * g + 1)) begin
            nx.gen[g][15:8] = reg_req.wdata;
          end
        end
      end
    end

    // register reads, data stands in the following cycle only
    if (reg_req.rd) begin
      if (reg_req.addr == `TCC_ADR_MODE) begin
        nx.rdata = r.mode;
      end else if (reg_req.addr == `TCC_ADR_CCTL) begin
        nx.rdata = r.cctl;
      end else if (reg_req.addr == `TCC_ADR_IEN) begin
        nx.rdata = r.ien | `TCC_RSV_ONES;
      end else if (reg_req.addr == `TCC_ADR_FLAGS) begin
        nx.rdata   = r.flags | `TCC_RSV_ONES;
        nx.rd_seen = r.rd_seen | (r.flags & `TCC_FLAG_VALID);
      end else if (reg_req.addr == `TCC_ADR_IOAB) begin
        nx.rdata = r.ioab;
      end else if (reg_req.addr == `TCC_ADR_IOCD) begin
        nx.rdata = r.iocd;
      end else if (reg_req.addr == `TCC_ADR_CNT_LO) begin
        nx.rdata = r.cnt[7:0];
      end else if (reg_req.addr == `TCC_ADR_CNT_HI) begin
        nx.rdata = r.cnt[15:8];
      end else if (reg_req.addr == `TCC_ADR_FILT) begin
        nx.rdata = r.filt;
      end else if (reg_req.addr == `TCC_ADR_OMASK) begin
        nx.rdata = r.omask;
      end else begin
        for (int g = 0; g < 4; g++) begin
          if (reg_req.addr == `TCC_ADR_GEN + 10'(2 * g)) begin
            nx.rdata = r.gen[g][7:0];
          end else if (reg_req.addr == `TCC_ADR_GEN + 10'(2 * g + 1)) begin
            nx.rdata = r.gen[g][15:8];
          end
        end
      end
    end

    // counter; clear on match a applies only when a compares
    if (tick) begin
      if (r.cctl[7] && match[0]) begin
        nx.cnt = 16'h0000;
      end else begin
        nx.cnt = r.cnt + 16'h0001;
      end
    end

    // channel a and its buffer c
    if (cap_ev[0]) begin
      if (bfc) begin
        nx.gen[2] = r.gen[0];
      end
      nx.gen[0] = r.cnt;
    end else if (match[0] && bfc) begin
      nx.gen[0] = r.gen[2];
    end
    if (cap_ev[2] && !bfc) begin
      nx.gen[2] = r.cnt;
    end

    // channel b and its buffer d; pwm2 reloads on a match or the trigger
    if (cap_ev[1]) begin
      if (bfd) begin
        nx.gen[3] = r.gen[1];
      end
      nx.gen[1] = r.cnt;
    end else if (bfd && pwm2_sel && (match[0] || trig_ev)) begin
      nx.gen[1] = r.gen[3];
    end else if (bfd && !pwm2_sel && match[1]) begin
      nx.gen[1] = r.gen[3];
    end
    if (cap_ev[3] && !bfd) begin
      nx.gen[3] = r.cnt;
    end

    // hardware set wins over a clear in the same cycle
    nx.flags = nx.flags | ev;

    // forced cutoff also wins over a software write
    if (r.omask[7] && !cutoff_input_pin_n) begin
      nx.omask[3:0] = 4'hf;
    end

    // request is registered so the output comes from a flop
    nx.req = {r.flags[7] & r.ien[7], r.flags[3:0] & r.ien[3:0]};
    nx.irq = pend;
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r         <= '0;
      r.mode    <= `TCC_RST_MODE;
      r.cctl    <= `TCC_RST_CCTL;
      r.ien     <= `TCC_RST_IEN;
      r.flags   <= `TCC_RST_FLAGS;
      r.ioab    <= `TCC_RST_IO;
      r.iocd    <= `TCC_RST_IO;
      r.filt    <= `TCC_RST_FILT;
      r.omask   <= `TCC_RST_OMASK;
    end else begin
      r <= nx;
    end
  end

  assign rd_data             = r.rdata;
  assign timer_irq           = r.irq;
  assign irq_req             = r.req;
  assign chan_output_disable = r.omask[3:0];

  // checks on the behaviour above
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_read_a_one;
    reg_req.rd && reg_req.addr == `TCC_ADR_FLAGS && r.flags[0];
  endsequence

  sequence s_write_a_zero;
    reg_req.wr && reg_req.addr == `TCC_ADR_FLAGS && !reg_req.wdata[0] && !ev[0];
  endsequence

  // one low sample, then a high one: a rising edge of the count clock pin
  sequence s_ext_rise;
    !external_count_clock_pin ##1 external_count_clock_pin;
  endsequence

  irq_gate_a: assert property (
    timer_irq == $past(pend) && irq_req[0] == $past(r.flags[0] & r.ien[0]))
    else $error("interrupt request does not follow flag and enable");

  rsv_ones_a: assert property (
    reg_req.rd && (reg_req.addr == `TCC_ADR_IEN || reg_req.addr == `TCC_ADR_FLAGS)
    |=> rd_data[6:4] == 3'h7)
    else $error("reserved bits did not read as one");

  clear_read_a: assert property (
    s_read_a_one ##1 s_write_a_zero |=> !r.flags[0])
    else $error("flag a not cleared by zero after read of one");

  no_blind_clr_a: assert property (
    reg_req.wr && reg_req.addr == `TCC_ADR_FLAGS && r.flags[1] && !r.rd_seen[1]
    |=> r.flags[1])
    else $error("flag b cleared without a prior read of one");

  flag_cause_a: assert property (
    $rose(r.flags[2]) |-> $past(ev[2]))
    else $error("flag c set without a hardware event");

  wrap_set_a: assert property (
    wrap_ev |=> r.flags[7] && r.cnt == 16'h0000)
    else $error("overflow did not set wrap flag");

  cap_buf_a: assert property (
    cap_ev[0] && bfc |=> r.gen[2] == $past(r.gen[0]) && r.gen[0] == $past(r.cnt))
    else $error("buffered capture order wrong");

  cmp_buf_a: assert property (
    match[0] && bfc && !reg_req.wr |=> r.gen[0] == $past(r.gen[2]))
    else $error("buffer not loaded into a on match");

  filt_three_a: assert property (
    filt_en[0] && samp_tick && $changed(nx.flvl[0]) |=> r.fsamp[0] == {3{r.flvl[0]}})
    else $error("filter level changed without three equal samples");

  cutoff_a: assert property (
    r.omask[7] && !cutoff_input_pin_n |-> ##[1:2] chan_output_disable == 4'hf)
    else $error("cutoff did not disable all outputs");

  pwm2_io_a: assert property (
    pwm2_sel |-> chan_cap == 4'h0)
    else $error("capture active in pwm2 operation");

  ones_keep_a: assert property (
    reg_req.wr && reg_req.addr == `TCC_ADR_FLAGS && reg_req.wdata[0] && r.flags[0]
    |=> r.flags[0])
    else $error("writing one changed flag a");

  wrap_gate_a: assert property (
    !r.ien[7] |=> !irq_req[4])
    else $error("wrap request passed with its enable clear");

  // the slow source is only sampled, so its edge shows one clock late
  slow_src_a: assert property (
    chan_cap[0] && !r.ioab[3] && r.ioab[1:0] == `TCC_EDGE_RISE && $rose(slow_osc_signal)
    |=> r.flags[0])
    else $error("slow oscillator edge not captured on channel a");

  ext_count_a: assert property (
    s_ext_rise ##0 (r.mode[7] && r.cctl[7:4] == {1'b0, `TCC_SRC_EXT} && !reg_req.wr)
    |=> r.cnt == $past(r.cnt) + 16'h0001)
    else $error("external clock edge not counted");

  fast_count_a: assert property (
    $rose(fast_osc_clock) && r.mode[7] && r.cctl[7:4] == {1'b0, `TCC_SRC_FAST}
    && !reg_req.wr |=> r.cnt == $past(r.cnt) + 16'h0001)
    else $error("fast oscillator edge not counted");

endmodule : tcc_top

`default_nettype wire

// ==== hdl/tcc_cfg.svh ====
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// Notes on behaviour
// - each channel and wrap request passes only when its enable bit is 1
// - bits 6 to 4 of enable and flag registers read 1, writes ignored
// - a flag clears only on a 0 write after a read returned 1
// - a flag that rose after a read of 0 survives the 0 write
// - writing 1 to a flag leaves it unchanged
// - capture channels set their flag on the edge chosen by the edge field
// - compare, pwm and pwm2 set the flag on counter equal general register
// - counter overflow sets the wrap flag in every mode
// - io control registers act in timer mode only, ignored in pwm and pwm2
// - mode select 0 is compare, 1 is capture; io registers reset to 88h
// - channel a capture source 0 is slow oscillator, 1 the pin
// - count source 101 counts external clock rising edges, 110 fast oscillator
// - buffer bits make c the buffer of a and d the buffer of b
// - buffered capture moves a (b) into its buffer before capturing
// - buffered compare or pwm loads the buffer into a (b) on match
// - buffered pwm2 loads d into b on match a or trigger input
// - buffering channels c and d still flag on their own pin edges
// - filter accepts a new level after three equal samples
// - low cutoff input with cutoff enabled sets all four output disables
// - count source 000 to 100 select clock divided by 1, 2, 4, 8, 32
// - operation clock is system clock for every source, 110 only samples the fast oscillator
`define TCC_AW          10
`define TCC_ADR_MODE    10'h120
`define TCC_ADR_CCTL    10'h121
`define TCC_ADR_IEN     10'h122
`define TCC_ADR_FLAGS   10'h123
`define TCC_ADR_IOAB    10'h124
`define TCC_ADR_IOCD    10'h125
`define TCC_ADR_CNT_LO  10'h126
`define TCC_ADR_CNT_HI  10'h127
`define TCC_ADR_GEN     10'h128
`define TCC_ADR_FILT    10'h131
`define TCC_ADR_OMASK   10'h132
`define TCC_RST_MODE    8'h48
`define TCC_RST_CCTL    8'h00
`define TCC_RST_IEN     8'h70
`define TCC_RST_FLAGS   8'h70
`define TCC_RST_IO      8'h88
`define TCC_RST_FILT    8'h00
`define TCC_RST_OMASK   8'h7f
`define TCC_RSV_ONES    8'h70
`define TCC_FLAG_VALID  8'h8f
`define TCC_MODE_ONES   8'h40
`define TCC_IOAB_ONES   8'h80
`define TCC_IOCD_ONES   8'h88
`define TCC_FILT_WMASK  8'hdf
`define TCC_SRC_DIV1    3'h0
`define TCC_SRC_DIV2    3'h1
`define TCC_SRC_DIV4    3'h2
`define TCC_SRC_DIV8    3'h3
`define TCC_SRC_DIV32   3'h4
`define TCC_SRC_EXT     3'h5
`define TCC_SRC_FAST    3'h6
`define TCC_EDGE_RISE   2'h0
`define TCC_EDGE_FALL   2'h1
`define TCC_EDGE_BOTH   2'h2
`define TCC_FILT_LEN    3
`define TCC_CNT_MAX     16'hffff
`endif

// ==== hdl/tcc_pkg.sv ====
package tcc_pkg;
  // one register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcc_bus_t;

  // whole state of the timer core
  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       cctl;
    logic [7:0]       ien;
    logic [7:0]       flags;
    logic [7:0]       rd_seen;
    logic [7:0]       ioab;
    logic [7:0]       iocd;
    logic [7:0]       filt;
    logic [7:0]       omask;
    logic [15:0]      cnt;
    logic [3:0][15:0] gen;
    logic [4:0]       presc;
    logic             ext_prev;
    logic             fast_prev;
    logic             slow_prev;
    logic [4:0][2:0]  fsamp;
    logic [4:0]       flvl;
    logic [4:0]       fprev;
    logic [7:0]       rdata;
    logic             irq;
    logic [4:0]       req;
  } tcc_state_t;
endpackage : tcc_pkg

// ==== tb/tcc_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module tcc_pin_model (
  // clock
  input  wire logic       clk_sys,
  // levels asked for by the bench
  input  wire logic [4:0] pin_lvl,
  input  wire logic       cut_lvl_n,
  input  wire logic       ext_run,
  // pins toward the timer, {trig, d, c, b, a}
  output var  logic [4:0] pins,
  output var  logic       cutoff_n,
  output var  logic       ext_clk,
  output var  logic       slow_osc,
  output var  logic       fast_osc
);
  logic [5:0] div;
  logic       run_q;

  // known levels before the first edge
  initial begin
    div      = 6'h00;
    run_q    = 1'b0;
    pins     = 5'h00;
    cutoff_n = 1'b1;
    ext_clk  = 1'b0;
    slow_osc = 1'b0;
    fast_osc = 1'b0;
  end

  // pins follow the bench one clock late, like a registered driver
  always @(posedge clk_sys) begin
    pins     <= pin_lvl;
    cutoff_n <= cut_lvl_n;
    div      <= div + 6'h01;
    slow_osc <= div[5];
    fast_osc <= ~fast_osc;
    // run is latched only before a high phase, so no pulse is ever cut short
    if (div[2:0] == 3'h3) begin
      run_q <= ext_run;
    end
    ext_clk <= div[2] & run_q;
  end
endmodule : tcc_pin_model

`default_nettype wire

// ==== tb/tb_timer_capture_compare_common.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"

module tb_timer_capture_compare_common
  import tcc_pkg::*;
;
  logic       clk_sys;
  logic       sys_rst;
  tcc_bus_t   req;
  logic [7:0] rd_data;
  logic [4:0] pin_lvl;
  logic       cut_lvl_n;
  logic       ext_run;
  logic [4:0] pins;
  logic       cutoff_n;
  logic       ext_clk;
  logic       slow_osc;
  logic       fast_osc;
  logic       timer_irq;
  logic [4:0] irq_req;
  logic [3:0] dis;
  logic       ext_q;
  int         n_errors;
  int         compares;
  int         ext_edges;
  int         m_flags;
  int         m_seen;

  tcc_pin_model u_pins (
    .clk_sys(clk_sys), .pin_lvl(pin_lvl), .cut_lvl_n(cut_lvl_n), .ext_run(ext_run),
    .pins(pins), .cutoff_n(cutoff_n), .ext_clk(ext_clk), .slow_osc(slow_osc),
    .fast_osc(fast_osc)
  );

  tcc_top #(.FILT_LEN(3)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(req), .rd_data(rd_data),
    .chan_a_pin(pins[0]), .chan_b_pin(pins[1]), .chan_c_pin(pins[2]),
    .chan_d_pin(pins[3]), .external_trigger_pin(pins[4]),
    .external_count_clock_pin(ext_clk), .cutoff_input_pin_n(cutoff_n),
    .slow_osc_signal(slow_osc), .fast_osc_clock(fast_osc),
    .timer_irq(timer_irq), .irq_req(irq_req), .chan_output_disable(dis)
  );

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // reference count of external clock rising edges
  always @(posedge clk_sys) begin
    ext_q <= ext_clk;
    if (ext_clk && !ext_q) ext_edges <= ext_edges + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_sys);
    req.wr    <= 1'b0;
  endtask : reg_wr

  // read data stand in the cycle after the strobe cycle only
  task automatic reg_rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys);
    req.rd   <= 1'b0;
    #1 d = rd_data;
  endtask : reg_rd

  task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
    logic [7:0] d;
    reg_rd(a, d);
    chk({8'h00, d}, exp);
  endtask : rd_chk

  task automatic wr16(input logic [9:0] a, input logic [15:0] v);
    reg_wr(a, v[7:0]);
    reg_wr(a + 10'h001, v[15:8]);
  endtask : wr16

  task automatic rd16_chk(input logic [9:0] a, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    reg_rd(a, lo);
    reg_rd(a + 10'h001, hi);
    chk({hi, lo}, exp);
  endtask : rd16_chk

  // flag model: a read remembers the ones, a write clears only those written 0
  task automatic flags_chk();
    rd_chk(`TCC_ADR_FLAGS, 16'(m_flags | 'h70));
    m_seen = m_flags;
  endtask : flags_chk

  task automatic flags_wr(input logic [7:0] v);
    reg_wr(`TCC_ADR_FLAGS, v);
    m_flags = m_flags & ~(m_seen & ~int'(v)) & 'h8f;
    m_seen  = 0;
  endtask : flags_wr

  // read the flags and write zero in the very next cycle, no gap
  task automatic flags_chk_clr();
    logic [7:0] d;
    @(posedge clk_sys);
    req.addr <= `TCC_ADR_FLAGS;
    req.rd   <= 1'b1;
    @(posedge clk_sys);
    req.rd    <= 1'b0;
    req.wdata <= 8'h00;
    req.wr    <= 1'b1;
    #1 d = rd_data;
    chk({8'h00, d}, 16'(m_flags | 'h70));
    @(posedge clk_sys);
    req.wr  <= 1'b0;
    m_flags = 0;
    m_seen  = 0;
  endtask : flags_chk_clr

  task automatic set_pin(input int ch, input logic lvl, input int hold);
    @(posedge clk_sys);
    pin_lvl[ch] <= lvl;
    repeat (hold) @(posedge clk_sys);
  endtask : set_pin

  task give_verdict;
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // a hang costs one mismatch and ends the run
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    give_verdict();
  end

  initial begin
    logic [7:0] v;
    sys_rst   = 1'b1;
    req       = '0;
    pin_lvl   = 5'h00;
    cut_lvl_n = 1'b1;
    ext_run   = 1'b0;
    ext_q     = 1'b0;
    n_errors  = 0;
    compares  = 0;
    ext_edges = 0;
    m_flags   = 0;
    m_seen    = 0;
    void'($urandom(60697));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // reset state and reserved bits
    #1 chk({12'h000, dis}, 16'h000f);
    chk({15'h0000, timer_irq}, 16'h0000);
    rd_chk(`TCC_ADR_IEN, 16'h0070);
    rd_chk(`TCC_ADR_FLAGS, 16'h0070);
    rd_chk(`TCC_ADR_IOAB, 16'h0088);
    rd_chk(`TCC_ADR_IOCD, 16'h0088);
    rd_chk(10'h3ff, 16'h0000);
    repeat (6) begin
      v = 8'($urandom);
      reg_wr(`TCC_ADR_IEN, v);
      rd_chk(`TCC_ADR_IEN, {8'h00, (v & 8'h8f) | 8'h70});
    end
    reg_wr(`TCC_ADR_IEN, 8'h00);
    // the rise, fall and both edge codes of channel a, pin as source
    for (int e = 0; e < 3; e++) begin
      reg_wr(`TCC_ADR_IOAB, 8'h0c | 8'(e));
      set_pin(0, 1'b1, 6);
      if (e != 1) m_flags |= 1;
      flags_chk_clr();
      set_pin(0, 1'b0, 6);
      if (e != 0) m_flags |= 1;
      flags_chk_clr();
    end
    // channel a capturing the slow oscillator instead of its pin
    reg_wr(`TCC_ADR_IOAB, 8'h04);
    repeat (70) @(posedge clk_sys);
    m_flags |= 1;
    flags_chk_clr();
    // rising edges only from here; clear needs a prior read of one
    reg_wr(`TCC_ADR_IOAB, 8'h0c);
    set_pin(0, 1'b1, 6);
    set_pin(0, 1'b0, 2);
    m_flags |= 1;
    flags_wr(8'h00);
    flags_wr(8'hff);
    flags_chk();
    // enable gating of the request
    reg_wr(`TCC_ADR_IEN, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk({15'h0000, timer_irq}, 16'h0001);
    chk({11'h000, irq_req}, 16'h0001);
    reg_wr(`TCC_ADR_IEN, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1 chk({10'h000, irq_req, timer_irq}, 16'h0000);
    flags_wr(8'h00);
    // flag rising after a read of zero survives the write
    flags_chk();
    set_pin(0, 1'b1, 6);
    set_pin(0, 1'b0, 2);
    m_flags |= 1;
    flags_wr(8'h00);
    flags_chk();
    flags_wr(8'h00);
    // filter: short pulse dropped, long pulse accepted
    reg_wr(`TCC_ADR_FILT, 8'h01);
    set_pin(0, 1'b1, 1);
    set_pin(0, 1'b0, 8);
    flags_chk();
    set_pin(0, 1'b1, 6);
    set_pin(0, 1'b0, 8);
    m_flags |= 1;
    flags_chk();
    flags_wr(8'h00);
    reg_wr(`TCC_ADR_FILT, 8'h00);
    // buffered capture, c follows a in mode
    reg_wr(`TCC_ADR_MODE, 8'h58);
    reg_wr(`TCC_ADR_IOCD, 8'h04);
    wr16(`TCC_ADR_CNT_LO, 16'h1234);
    set_pin(0, 1'b1, 6);
    set_pin(0, 1'b0, 2);
    wr16(`TCC_ADR_CNT_LO, 16'h5678);
    set_pin(0, 1'b1, 6);
    set_pin(0, 1'b0, 2);
    rd16_chk(`TCC_ADR_GEN, 16'h5678);
    rd16_chk(`TCC_ADR_GEN + 10'h004, 16'h1234);
    set_pin(2, 1'b1, 6);
    set_pin(2, 1'b0, 2);
    m_flags |= 5;
    flags_chk();
    rd16_chk(`TCC_ADR_GEN + 10'h004, 16'h1234);
    flags_wr(8'h00);
    // external clock counting, compare mode again
    reg_wr(`TCC_ADR_IOAB, 8'h88);
    reg_wr(`TCC_ADR_IOCD, 8'h88);
    reg_wr(`TCC_ADR_MODE, 8'h48);
    reg_wr(`TCC_ADR_CCTL, 8'h50);
    wr16(`TCC_ADR_CNT_LO, 16'h0000);
    reg_wr(`TCC_ADR_MODE, 8'hc8);
    ext_edges = 0;
    ext_run <= 1'b1;
    repeat (100) @(posedge clk_sys);
    ext_run <= 1'b0;
    repeat (16) @(posedge clk_sys);
    reg_wr(`TCC_ADR_MODE, 8'h48);
    rd16_chk(`TCC_ADR_CNT_LO, 16'(ext_edges));
    // counting from zero matches b and d, whose general registers hold zero
    m_flags = 'h0a;
    flags_chk_clr();
    // fast oscillator: 22 ticked edges hold 11 rising edges
    reg_wr(`TCC_ADR_CCTL, 8'h60);
    wr16(`TCC_ADR_CNT_LO, 16'h0100);
    reg_wr(`TCC_ADR_MODE, 8'hc8);
    repeat (20) @(posedge clk_sys);
    reg_wr(`TCC_ADR_MODE, 8'h48);
    rd16_chk(`TCC_ADR_CNT_LO, 16'h010b);
    // overflow and compare match on b and d at zero, three ticks
    reg_wr(`TCC_ADR_CCTL, 8'h00);
    wr16(`TCC_ADR_CNT_LO, 16'hfffe);
    reg_wr(`TCC_ADR_MODE, 8'hc8);
    @(posedge clk_sys);
    reg_wr(`TCC_ADR_MODE, 8'h48);
    m_flags = 'h8a;
    flags_wr(8'h00);
    flags_chk();
    flags_wr(8'h00);
    // buffered compare: a match on a reloads a from its buffer c
    reg_wr(`TCC_ADR_MODE, 8'h58);
    wr16(`TCC_ADR_GEN, 16'h0005);
    wr16(`TCC_ADR_GEN + 10'h004, 16'h0040);
    wr16(`TCC_ADR_CNT_LO, 16'h0004);
    reg_wr(`TCC_ADR_MODE, 8'hd8);
    @(posedge clk_sys);
    reg_wr(`TCC_ADR_MODE, 8'h58);
    rd16_chk(`TCC_ADR_GEN, 16'h0040);
    m_flags = 1;
    flags_chk_clr();
    // forced cutoff from the low cutoff pin
    reg_wr(`TCC_ADR_OMASK, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1 chk({12'h000, dis}, 16'h0000);
    cut_lvl_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk({12'h000, dis}, 16'h000f);
    cut_lvl_n <= 1'b1;
    rd_chk(`TCC_ADR_OMASK, 16'h00ff);
    give_verdict();
  end
endmodule : tb_timer_capture_compare_common

`default_nettype wire
